/* File: verilog/mspm_pkg.sv */
package mspm_pkg;
  // strap code bits {bit3,bit2,bit1,bit0}
  localparam logic [3:0] STRAP_SINGLE_SERIAL = 4'h4;
  localparam logic [3:0] STRAP_TWO_SER_ONE_PAR = 4'h6;
  localparam logic [3:0] STRAP_TWO_SER_EXP = 4'h5;
  localparam logic [3:0] STRAP_SINGLE_PAR = 4'h3;
  localparam logic [3:0] STRAP_DUAL_PAR = 4'h2;
  // pin group widths
  localparam int SER_PINS = 8;
  localparam int PAR_PINS = 20;
  localparam int SPARE_PINS = 4;
  // strap bit positions within the spare group and parallel group
  localparam int PAR_DIR_BIT = 17;
  localparam int PAR_HVALID_BIT = 19;
  localparam int SPARE_BIT0 = 0;
  localparam int SPARE_BIT1 = 2;
  // strap capture delay in cycles after reset release
  localparam logic [1:0] CAPTURE_CYCLES = 2'h2;

  typedef enum logic [5:0] {
    MSPM_WAIT = 6'h01,
    MSPM_SINGLE_SERIAL = 6'h02,
    MSPM_TWO_SER_ONE_PAR = 6'h04,
    MSPM_TWO_SER_EXP = 6'h08,
    MSPM_SINGLE_PAR = 6'h10,
    MSPM_DUAL_PAR = 6'h20
  } mspm_mode_e;

  // parallel port core side signals
  typedef struct packed {
    logic [7:0] data_out;
    logic data_oe;
    logic strobe_n;
    logic linefeed_n;
    logic init_n;
    logic select_in_n;
    logic direction;
    logic host_valid;
  } mspm_par_out_s;

  typedef struct packed {
    logic [7:0] data_in;
    logic ack_n;
    logic not_ready;
    logic paper_out;
    logic online;
    logic fault_n;
    logic far_valid;
  } mspm_par_in_s;

  // serial port core side signals
  typedef struct packed {
    logic tx;
    logic term_ready_n;
    logic req_to_send_n;
  } mspm_ser_out_s;

  typedef struct packed {
    logic rx;
    logic clear_to_send_n;
    logic carrier_n;
    logic set_ready_n;
    logic ring_n;
  } mspm_ser_in_s;

  // expansion bus core side signals
  typedef struct packed {
    logic [7:0] data_out;
    logic data_oe;
    logic [2:0] addr;
    logic read_n;
    logic write_n;
    logic periph_reset;
    logic reserved_line;
    logic sel_a_n;
    logic sel_b_n;
    logic sel_c_n;
    logic sel_d_n;
  } mspm_exp_out_s;

  typedef struct packed {
    logic [7:0] data_in;
    logic exp_irq_a;
    logic exp_irq_b;
    logic exp_irq_c;
    logic exp_irq_d;
  } mspm_exp_in_s;
endpackage

/* File: verilog/mspm_pin_mux.sv */
// Notes on behaviour
// - mode comes only from the captured strap register, never from software.
// - straps sampled once right after reset release, then held.
// - five strap codes select five modes; board pulls each strap pin.
// - single-serial mode drives only serial port one; other shared pin groups undriven.
// - dual-parallel puts second parallel data on serial-one pins in mapped order.
// - dual-parallel puts second parallel control on serial-two and spare pins.
// - expansion mode maps busy, ack, paper-end, select to irq c, b, a, d.
// - expansion mode maps strobes, init, select-in, error, direction pins as listed.
// - general purpose pins are never multiplexed in any mode.
// - data stays valid while strobe is low.
// - init and select-in active low; init is open-drain.
// - data bus driven in compatibility, idle in nibble, bidirectional otherwise.
// - direction high host-to-peripheral, low peripheral-to-host.
// - host-valid high only while host lines valid; far valid low when off.
// - serial modem controls are active low.
// - serial tx and rx serve transceiver or infrared parts alike.
// - expansion reads and writes use separate active-low strobes.
`timescale 1ns/10ps
module mspm_pin_mux
  import mspm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // core side: serial ports
  input wire mspm_ser_out_s ser1_core_out,
  input wire mspm_ser_out_s ser2_core_out,
  output mspm_ser_in_s ser1_core_in,
  output mspm_ser_in_s ser2_core_in,
  // core side: parallel ports
  input wire mspm_par_out_s par1_core_out,
  input wire mspm_par_out_s par2_core_out,
  output mspm_par_in_s par1_core_in,
  output mspm_par_in_s par2_core_in,
  // core side: expansion bus
  input wire mspm_exp_out_s exp_core_out,
  output mspm_exp_in_s exp_core_in,
  // core side: general purpose lines
  input wire logic [3:0] gpio_core_out,
  input wire logic [3:0] gpio_core_oe,
  output logic [3:0] gpio_core_in,
  // mode status
  output logic [3:0] strap_value,
  output logic strap_valid,
  output logic [5:0] mode_onehot,
  // serial one pin group (8 pins)
  input wire logic [SER_PINS-1:0] ser1_pin_in,
  output logic [SER_PINS-1:0] ser1_pin_out,
  output logic [SER_PINS-1:0] ser1_pin_oe,
  // serial two pin group (8 pins)
  input wire logic [SER_PINS-1:0] ser2_pin_in,
  output logic [SER_PINS-1:0] ser2_pin_out,
  output logic [SER_PINS-1:0] ser2_pin_oe,
  // parallel one pin group (20 pins)
  input wire logic [PAR_PINS-1:0] par_pin_in,
  output logic [PAR_PINS-1:0] par_pin_out,
  output logic [PAR_PINS-1:0] par_pin_oe,
  // spare pin group (4 pins)
  input wire logic [SPARE_PINS-1:0] spare_pin_in,
  output logic [SPARE_PINS-1:0] spare_pin_out,
  output logic [SPARE_PINS-1:0] spare_pin_oe,
  // general purpose pins
  input wire logic [3:0] gpio_pin_in,
  output logic [3:0] gpio_pin_out,
  output logic [3:0] gpio_pin_oe
);

  // serial pin order: 0 ctsn,1 dcdn,2 dsrn,3 rin,4 rxd,5 dtrn,6 rtsn,7 txd
  // parallel pin order: 0-7 data,8 busy,9 ack,10 paper,11 select,12 fault,
  // 13 select-in,14 init,15 linefeed,16 strobe,17 dir,18 far valid,19 host valid
  // spare order: 0 strap0 pin,1 far-valid2,2 strap1 pin,3 select2
  // in the serial modes only txd, rtsn and dtrn drive; the other five serial pins are inputs
  localparam logic [SER_PINS-1:0] SER_OUT_MASK = 8'hE0;

  // input synchronisers: first stage feeds only the second
  // every pin is asynchronous to clk_sys, so no logic reads a first stage
  logic [SER_PINS-1:0] s1_meta_reg;
  logic [SER_PINS-1:0] s1_sync_reg;
  logic [SER_PINS-1:0] s2_meta_reg;
  logic [SER_PINS-1:0] s2_sync_reg;
  logic [PAR_PINS-1:0] p_meta_reg;
  logic [PAR_PINS-1:0] p_sync_reg;
  logic [SPARE_PINS-1:0] x_meta_reg;
  logic [SPARE_PINS-1:0] x_sync_reg;
  logic [3:0] g_meta_reg;
  logic [3:0] g_sync_reg;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s1_meta_reg <= 8'h00;
      s1_sync_reg <= 8'h00;
      s2_meta_reg <= 8'h00;
      s2_sync_reg <= 8'h00;
      p_meta_reg <= 20'h00000;
      p_sync_reg <= 20'h00000;
      x_meta_reg <= 4'h0;
      x_sync_reg <= 4'h0;
      g_meta_reg <= 4'h0;
      g_sync_reg <= 4'h0;
    end else begin
      s1_meta_reg <= ser1_pin_in;
      s1_sync_reg <= s1_meta_reg;
      s2_meta_reg <= ser2_pin_in;
      s2_sync_reg <= s2_meta_reg;
      p_meta_reg <= par_pin_in;
      p_sync_reg <= p_meta_reg;
      x_meta_reg <= spare_pin_in;
      x_sync_reg <= x_meta_reg;
      g_meta_reg <= gpio_pin_in;
      g_sync_reg <= g_meta_reg;
    end
  end

  // strap capture: wait for synchronisers to fill after release, then latch once
  // the short wait keeps the reset-zero sync stages out of the strap code
  mspm_mode_e mode_reg;
  mspm_mode_e mode_next;
  logic [1:0] cap_cnt_reg;
  logic [1:0] cap_cnt_next;
  logic [3:0] strap_reg;
  logic [3:0] strap_next;
  logic [3:0] strap_now;

  always_comb begin
    strap_now = {p_sync_reg[PAR_DIR_BIT], p_sync_reg[PAR_HVALID_BIT],
                 x_sync_reg[SPARE_BIT1], x_sync_reg[SPARE_BIT0]};
    mode_next = mode_reg;
    cap_cnt_next = cap_cnt_reg;
    strap_next = strap_reg;
    case (mode_reg)
      MSPM_WAIT: begin
        // both sync stages must hold real pin levels before the capture
        if (cap_cnt_reg != CAPTURE_CYCLES) begin
          cap_cnt_next = cap_cnt_reg + 2'h1;
        end else begin
          strap_next = strap_now;
          // unknown codes fall back to single serial, the least-driving mode
          case (strap_now)
            STRAP_TWO_SER_ONE_PAR: mode_next = MSPM_TWO_SER_ONE_PAR;
            STRAP_TWO_SER_EXP: mode_next = MSPM_TWO_SER_EXP;
            STRAP_SINGLE_PAR: mode_next = MSPM_SINGLE_PAR;
            STRAP_DUAL_PAR: mode_next = MSPM_DUAL_PAR;
            default: mode_next = MSPM_SINGLE_SERIAL;
          endcase
        end
      end
      default: begin
        // no path leaves a mode; only reset returns to wait
        mode_next = mode_reg; // held until next reset
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= MSPM_WAIT;
      cap_cnt_reg <= 2'h0;
      strap_reg <= 4'h0;
    end else begin
      mode_reg <= mode_next;
      cap_cnt_reg <= cap_cnt_next;
      strap_reg <= strap_next;
    end
  end

  // pin routing per mode; everything undriven by default
  logic [SER_PINS-1:0] s1_out_next;
  logic [SER_PINS-1:0] s1_oe_next;
  logic [SER_PINS-1:0] s2_out_next;
  logic [SER_PINS-1:0] s2_oe_next;
  logic [PAR_PINS-1:0] p_out_next;
  logic [PAR_PINS-1:0] p_oe_next;
  logic [SPARE_PINS-1:0] x_out_next;
  logic [SPARE_PINS-1:0] x_oe_next;
  mspm_ser_in_s ser1_in_next;
  mspm_ser_in_s ser2_in_next;
  mspm_par_in_s par1_in_next;
  mspm_par_in_s par2_in_next;
  mspm_exp_in_s exp_in_next;

  // serial pin group helper values; modem lines pass unchanged, active low
  function automatic logic [SER_PINS-1:0] ser_drive(input mspm_ser_out_s so);
    ser_drive = {so.tx, so.req_to_send_n, so.term_ready_n, 5'h00};
  endfunction

  // serial input pins gathered back into the core-side struct
  function automatic mspm_ser_in_s ser_take(input logic [SER_PINS-1:0] p);
    ser_take = '{rx: p[4], clear_to_send_n: p[0], carrier_n: p[1],
                 set_ready_n: p[2], ring_n: p[3]};
  endfunction

  always_comb begin
    // defaults: every pin released, every core input idle
    s1_out_next = 8'h00;
    s1_oe_next = 8'h00;
    s2_out_next = 8'h00;
    s2_oe_next = 8'h00;
    p_out_next = 20'h00000;
    p_oe_next = 20'h00000;
    x_out_next = 4'h0;
    x_oe_next = 4'h0;
    // idle inputs: lines read inactive when not routed, except not_ready, which reads busy
    ser1_in_next = '{rx: 1'b1, clear_to_send_n: 1'b1, carrier_n: 1'b1,
                     set_ready_n: 1'b1, ring_n: 1'b1};
    ser2_in_next = ser1_in_next;
    par1_in_next = '{data_in: 8'h00, ack_n: 1'b1, not_ready: 1'b1, paper_out: 1'b0,
                     online: 1'b0, fault_n: 1'b1, far_valid: 1'b0};
    par2_in_next = par1_in_next;
    exp_in_next = '{data_in: 8'h00, exp_irq_a: 1'b0, exp_irq_b: 1'b0,
                    exp_irq_c: 1'b0, exp_irq_d: 1'b0};

    // serial ports: one in single-serial mode, both in the two-serial modes
    case (mode_reg)
      MSPM_SINGLE_SERIAL: begin
        s1_out_next = ser_drive(ser1_core_out);
        s1_oe_next = SER_OUT_MASK;
        ser1_in_next = ser_take(s1_sync_reg);
      end
      MSPM_TWO_SER_ONE_PAR, MSPM_TWO_SER_EXP: begin
        s1_out_next = ser_drive(ser1_core_out);
        s1_oe_next = SER_OUT_MASK;
        ser1_in_next = ser_take(s1_sync_reg);
        s2_out_next = ser_drive(ser2_core_out);
        s2_oe_next = SER_OUT_MASK;
        ser2_in_next = ser_take(s2_sync_reg);
      end
      default: begin
      end
    endcase

    // first parallel port in three modes
    if (mode_reg == MSPM_TWO_SER_ONE_PAR || mode_reg == MSPM_SINGLE_PAR || mode_reg == MSPM_DUAL_PAR) begin
      p_out_next = {par1_core_out.host_valid, 1'b0, par1_core_out.direction,
                    par1_core_out.strobe_n, par1_core_out.linefeed_n, 1'b0,
                    par1_core_out.select_in_n, 5'h00, par1_core_out.data_out};
      // init open-drain: enabled only when pulling low
      p_oe_next = {1'b1, 1'b0, 1'b1, 1'b1, 1'b1,
                   ~par1_core_out.init_n, 1'b1, 5'h00,
                   {8{par1_core_out.data_oe}}};
      par1_in_next = '{data_in: p_sync_reg[7:0], ack_n: p_sync_reg[9], not_ready: p_sync_reg[8],
                       paper_out: p_sync_reg[10], online: p_sync_reg[11],
                       fault_n: p_sync_reg[12], far_valid: p_sync_reg[18]};
    end

    // expansion bus on the parallel pins
    if (mode_reg == MSPM_TWO_SER_EXP) begin
      p_out_next = {exp_core_out.addr[2], exp_core_out.addr[1], exp_core_out.addr[0],
                    exp_core_out.read_n, exp_core_out.write_n, exp_core_out.periph_reset,
                    exp_core_out.reserved_line, exp_core_out.sel_b_n, 4'h0, exp_core_out.data_out};
      p_oe_next = {8'hFF, 4'h0, {8{exp_core_out.data_oe}}};
      x_out_next = {exp_core_out.sel_d_n, exp_core_out.sel_c_n, 1'b0, exp_core_out.sel_a_n};
      x_oe_next = 4'hD;
      exp_in_next = '{data_in: p_sync_reg[7:0], exp_irq_a: p_sync_reg[10], exp_irq_b: p_sync_reg[9],
                      exp_irq_c: p_sync_reg[8], exp_irq_d: p_sync_reg[11]};
    end

    // second parallel port over serial and spare pins
    // serial cores keep idle inputs here; their pins now belong to port two
    if (mode_reg == MSPM_DUAL_PAR) begin
      s1_out_next = {par2_core_out.data_out[7], par2_core_out.data_out[5], par2_core_out.data_out[6],
                     par2_core_out.data_out[4], par2_core_out.data_out[0], par2_core_out.data_out[3],
                     par2_core_out.data_out[1], par2_core_out.data_out[2]};
      s1_oe_next = {8{par2_core_out.data_oe}};
      s2_out_next = {par2_core_out.strobe_n, 1'b0, par2_core_out.linefeed_n,
                     par2_core_out.select_in_n, 4'h0};
      s2_oe_next = {1'b1, ~par2_core_out.init_n, 1'b1, 1'b1, 4'h0};
      x_out_next = {1'b0, par2_core_out.host_valid, 1'b0, par2_core_out.direction};
      x_oe_next = 4'h5;
      par2_in_next = '{data_in: {s1_sync_reg[7], s1_sync_reg[5], s1_sync_reg[6], s1_sync_reg[4],
                                 s1_sync_reg[2], s1_sync_reg[0], s1_sync_reg[1], s1_sync_reg[3]},
                       ack_n: s2_sync_reg[0], not_ready: s2_sync_reg[1], fault_n: s2_sync_reg[2],
                       paper_out: s2_sync_reg[3], online: x_sync_reg[3], far_valid: x_sync_reg[1]};
    end
  end

  // pin output registers; wait state leaves every pin enable low except the gpio enables, which follow gpio_core_oe
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ser1_pin_out <= 8'h00;
      ser1_pin_oe <= 8'h00;
      ser2_pin_out <= 8'h00;
      ser2_pin_oe <= 8'h00;
      par_pin_out <= 20'h00000;
      par_pin_oe <= 20'h00000;
      spare_pin_out <= 4'h0;
      spare_pin_oe <= 4'h0;
      gpio_pin_out <= 4'h0;
      gpio_pin_oe <= 4'h0;
    end else begin
      ser1_pin_out <= s1_out_next;
      ser1_pin_oe <= s1_oe_next;
      ser2_pin_out <= s2_out_next;
      ser2_pin_oe <= s2_oe_next;
      par_pin_out <= p_out_next;
      par_pin_oe <= p_oe_next;
      spare_pin_out <= x_out_next;
      spare_pin_oe <= x_oe_next;
      gpio_pin_out <= gpio_core_out;
      gpio_pin_oe <= gpio_core_oe;
    end
  end

  // core-side input registers; with the sync stages the core sees a pin three edges late
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ser1_core_in <= '1;
      ser2_core_in <= '1;
      par1_core_in <= '0;
      par2_core_in <= '0;
      exp_core_in <= '0;
      gpio_core_in <= 4'h0;
    end else begin
      ser1_core_in <= ser1_in_next;
      ser2_core_in <= ser2_in_next;
      par1_core_in <= par1_in_next;
      par2_core_in <= par2_in_next;
      exp_core_in <= exp_in_next;
      gpio_core_in <= g_sync_reg;
    end
  end

  // status outputs from flops
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      strap_value <= 4'h0;
      strap_valid <= 1'b0;
      mode_onehot <= 6'h01;
    end else begin
      strap_value <= strap_next;
      // next values, so status rises at the capture edge itself
      strap_valid <= (mode_next != MSPM_WAIT);
      mode_onehot <= mode_next;
    end
  end

endmodule

/* File: testbench/mspm_pin_mux_assertions.sv */
`timescale 1ns/10ps
module mspm_pin_mux_check
  import mspm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // core side
  input wire mspm_par_out_s par1_core_out,
  input wire mspm_par_out_s par2_core_out,
  input wire mspm_exp_out_s exp_core_out,
  input wire logic [3:0] gpio_core_out,
  // mode status
  input wire logic [3:0] strap_value,
  input wire logic strap_valid,
  input wire logic [5:0] mode_onehot,
  // pins
  input wire logic [SER_PINS-1:0] ser1_pin_out,
  input wire logic [SER_PINS-1:0] ser1_pin_oe,
  input wire logic [SER_PINS-1:0] ser2_pin_oe,
  input wire logic [PAR_PINS-1:0] par_pin_in,
  input wire logic [PAR_PINS-1:0] par_pin_out,
  input wire logic [PAR_PINS-1:0] par_pin_oe,
  input wire logic [SPARE_PINS-1:0] spare_pin_in,
  input wire logic [SPARE_PINS-1:0] spare_pin_oe,
  input wire logic [3:0] gpio_pin_out
);
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  default clocking dcb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // edges since reset release, saturating so it never wraps into a false capture
  always_comb begin
    cnt_next = (cnt_reg == 3'h7) ? cnt_reg : cnt_reg + 3'h1;
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 3'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  strap_hold_a: assert property (strap_valid |=> strap_valid && $stable(strap_value))
    else $error("strap value moved after capture");
  capture_time_a: assert property (strap_valid == (cnt_reg >= 3'h3))
    else $error("strap capture at wrong edge");
  // compare with the pins as sampled at the first edge after release, ahead of both sync stages
  strap_sample_a: assert property ($rose(strap_valid) |->
    strap_value == $past({par_pin_in[17], par_pin_in[19], spare_pin_in[2], spare_pin_in[0]}, 3))
    else $error("captured straps differ from pins");
  wait_undriven_a: assert property (!strap_valid |-> (par_pin_oe | spare_pin_oe) == 0
    && (ser1_pin_oe | ser2_pin_oe) == 0)
    else $error("shared pin driven before capture");
  gpio_pass_a: assert property (cnt_reg >= 3'h2 |-> gpio_pin_out == $past(gpio_core_out))
    else $error("general purpose path broken");
  single_serial_a: assert property (mode_onehot == 6'h02 && $past(strap_valid) |->
    (par_pin_oe | spare_pin_oe) == 0 && ser2_pin_oe == 0)
    else $error("pin driven in single serial mode");
  single_par_a: assert property (mode_onehot == 6'h10 && $past(strap_valid) |->
    (ser1_pin_oe | ser2_pin_oe) == 0 && spare_pin_oe == 0)
    else $error("serial pin driven in single parallel mode");
  par_strobe_a: assert property (mode_onehot == 6'h04 && $past(strap_valid) |->
    par_pin_oe[16] && par_pin_out[16] == $past(par1_core_out.strobe_n))
    else $error("strobe pin does not follow port one");
  exp_strobe_a: assert property (mode_onehot == 6'h08 && $past(strap_valid) |->
    par_pin_out[16:15] == $past({exp_core_out.read_n, exp_core_out.write_n}))
    else $error("expansion strobes misrouted");
  dual_data_a: assert property (mode_onehot == 6'h20 && $past(strap_valid) |->
    ser1_pin_out == $past({par2_core_out.data_out[7], par2_core_out.data_out[5], par2_core_out.data_out[6],
    par2_core_out.data_out[4], par2_core_out.data_out[0], par2_core_out.data_out[3],
    par2_core_out.data_out[1], par2_core_out.data_out[2]}))
    else $error("second parallel data misplaced");
endmodule
bind mspm_pin_mux mspm_pin_mux_check u_check (.clk_sys(clk_sys), .rst_b(rst_b),
  .par1_core_out(par1_core_out), .par2_core_out(par2_core_out), .exp_core_out(exp_core_out),
  .gpio_core_out(gpio_core_out), .strap_value(strap_value), .strap_valid(strap_valid),
  .mode_onehot(mode_onehot), .ser1_pin_out(ser1_pin_out), .ser1_pin_oe(ser1_pin_oe),
  .ser2_pin_oe(ser2_pin_oe), .par_pin_in(par_pin_in), .par_pin_out(par_pin_out), .par_pin_oe(par_pin_oe),
  .spare_pin_in(spare_pin_in), .spare_pin_oe(spare_pin_oe), .gpio_pin_out(gpio_pin_out));

/* File: testbench/mspm_far_side.sv */
`timescale 1ns/10ps
module mspm_far_side
  import mspm_pkg::*;
(
  // clock and board settings
  input wire logic clk_sys,
  input wire logic [3:0] strap_code,
  input wire logic paper_out_req,
  input wire logic [7:0] far_data,
  // parallel and spare pin groups
  input wire logic [PAR_PINS-1:0] par_pin_out,
  input wire logic [PAR_PINS-1:0] par_pin_oe,
  output logic [PAR_PINS-1:0] par_pin_in,
  input wire logic [SPARE_PINS-1:0] spare_pin_out,
  input wire logic [SPARE_PINS-1:0] spare_pin_oe,
  output logic [SPARE_PINS-1:0] spare_pin_in
);
  logic [1:0] ack_cnt = 2'h0;
  logic [PAR_PINS-1:0] far_par;
  // a strobe low starts a short busy span that ends with one ack cycle
  always @(posedge clk_sys) begin
    if (par_pin_oe[16] && !par_pin_out[16] && ack_cnt == 2'h0) begin
      ack_cnt <= 2'h3;
    end else if (ack_cnt != 2'h0) begin
      ack_cnt <= ack_cnt - 2'h1;
    end
  end
  // released lines show the pull level on straps, far_data on data, model levels on 8-12 and 18, else the inverse of the driven value
  always_comb begin
    far_par = ~par_pin_out;
    far_par[7:0] = far_data;
    far_par[8] = (ack_cnt != 2'h0);
    far_par[9] = (ack_cnt != 2'h1);
    far_par[10] = paper_out_req;
    far_par[11] = 1'b1;
    far_par[12] = !paper_out_req;
    far_par[17] = strap_code[3];
    far_par[19] = strap_code[2];
    far_par[18] = 1'b1;
    par_pin_in = (par_pin_oe & par_pin_out) | (~par_pin_oe & far_par);
    spare_pin_in = (spare_pin_oe & spare_pin_out) |
      (~spare_pin_oe & {~spare_pin_out[3], strap_code[1], 1'b1, strap_code[0]});
  end
endmodule

/* File: testbench/test_mode_strapped_port_pin_mux.sv */
`timescale 1ns/10ps
module test_mode_strapped_port_pin_mux;
  import mspm_pkg::*;
  localparam logic [7:0] FAR_S1 = 8'h5A;
  localparam logic [7:0] FAR_D = 8'h81;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] strap_code = 4'h4;
  logic paper_out_req = 1'b0;
  logic [3:0] gpo = 4'h0;
  logic [3:0] gpe = 4'h0;
  logic [3:0] gci, sv, gpin_out, gpin_oe, gpin_in, spi, spo, soe;
  logic sval, seen_ack, seen_busy;
  logic [5:0] moh;
  logic [7:0] s1pi, s1po, s1oe, s2pi, s2po, s2oe;
  logic [19:0] ppi, ppo, poe;
  mspm_ser_out_s s1o, s2o;
  mspm_ser_in_s s1i, s2i;
  mspm_par_out_s p1o, p2o;
  mspm_par_in_s p1i, p2i;
  mspm_exp_out_s eo;
  mspm_exp_in_s ei;
  int err_total = 0;
  int checks = 0;
  logic [3:0] codes [6] = '{STRAP_SINGLE_SERIAL, STRAP_TWO_SER_ONE_PAR, STRAP_TWO_SER_EXP,
    STRAP_SINGLE_PAR, STRAP_DUAL_PAR, 4'hF};
  logic [5:0] modes [6] = '{6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h02};
  // serial and gpio far ends resolved here, parallel side by the model
  assign s1pi = (s1oe & s1po) | (~s1oe & FAR_S1);
  assign s2pi = (s2oe & s2po) | (~s2oe & 8'hC3);
  assign gpin_in = (gpin_oe & gpin_out) | (~gpin_oe & 4'h9);
  mspm_pin_mux dut (.clk_sys(clk_sys), .rst_b(rst_b), .ser1_core_out(s1o), .ser2_core_out(s2o),
    .ser1_core_in(s1i), .ser2_core_in(s2i), .par1_core_out(p1o), .par2_core_out(p2o),
    .par1_core_in(p1i), .par2_core_in(p2i), .exp_core_out(eo), .exp_core_in(ei),
    .gpio_core_out(gpo), .gpio_core_oe(gpe), .gpio_core_in(gci), .strap_value(sv), .strap_valid(sval),
    .mode_onehot(moh), .ser1_pin_in(s1pi), .ser1_pin_out(s1po), .ser1_pin_oe(s1oe), .ser2_pin_in(s2pi),
    .ser2_pin_out(s2po), .ser2_pin_oe(s2oe), .par_pin_in(ppi), .par_pin_out(ppo), .par_pin_oe(poe),
    .spare_pin_in(spi), .spare_pin_out(spo), .spare_pin_oe(soe), .gpio_pin_in(gpin_in),
    .gpio_pin_out(gpin_out), .gpio_pin_oe(gpin_oe));
  mspm_far_side far (.clk_sys(clk_sys), .strap_code(strap_code), .paper_out_req(paper_out_req),
    .far_data(FAR_D), .par_pin_out(ppo), .par_pin_oe(poe), .par_pin_in(ppi),
    .spare_pin_out(spo), .spare_pin_oe(soe), .spare_pin_in(spi));
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  // inputs always move 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // run is under a hundred cycles, so this limit only trips on a hang
  initial begin
    #50000;
    err_total++;
    final_report;
  end
  initial begin
    s1o = '{1'b1, 1'b0, 1'b1};
    s2o = '{1'b0, 1'b1, 1'b0};
    p1o = '{8'hA5, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    p2o = '{8'h3C, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
    eo = '{8'h96, 1'b1, 3'h5, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    // each mode needs its own reset, the captured straps hold when the strap pins move afterwards
    for (int m = 0; m < 6; m++) begin
      rst_b = 1'b0;
      strap_code = codes[m];
      paper_out_req = 1'b0;
      p1o.data_oe = 1'b1;
      step(5);
      rst_b = 1'b1;
      step(2);
      chk({sval, poe}, 21'h0);
      step(1);
      chk({sval, sv, moh}, {1'b1, codes[m], modes[m]});
      strap_code = ~codes[m];
      gpo = codes[m];
      gpe = ~codes[m];
      step(4);
      chk(sv, codes[m]);
      chk({gpin_out, gpin_oe, gci}, {gpo, gpe, (gpe & gpo) | (~gpe & 4'h9)});
      if (m == 0 || m == 5) begin
        chk({poe, soe, s2oe}, 32'h0);
        chk({s1po[7:5], s1i.rx, s1i.clear_to_send_n}, {s1o.tx, s1o.req_to_send_n, s1o.term_ready_n,
          FAR_S1[4], FAR_S1[0]});
        chk(s2i, 5'h1F);
      end else if (m == 1) begin
        chk({ppo[19], ppo[17], ppo[16], ppo[7:0]}, {p1o.host_valid, p1o.direction, 1'b1, 8'hA5});
        chk({poe[14], ppo[14], s2po[7]}, {~p1o.init_n, 1'b0, s2o.tx});
        chk({s2i.rx, s2i.clear_to_send_n, s2i.carrier_n, s2i.set_ready_n, s2i.ring_n, p1i.far_valid},
          6'b011001);
        paper_out_req = 1'b1;
        step(4);
        chk({p1i.paper_out, p1i.fault_n, p1i.online}, 3'b101);
      end else if (m == 2) begin
        chk({ppo[19:12], ppo[7:0]}, {eo.addr[2], eo.addr[1], eo.addr[0], eo.read_n, eo.write_n,
          eo.periph_reset, eo.reserved_line, eo.sel_b_n, eo.data_out});
        chk({spo[3], spo[2], spo[0]}, {eo.sel_d_n, eo.sel_c_n, eo.sel_a_n});
        chk({ei.exp_irq_c, ei.exp_irq_b, ei.exp_irq_a, ei.exp_irq_d}, 4'b0101);
        chk(ei.data_in, eo.data_out);
      end else if (m == 3) begin
        chk({s1oe, s2oe, soe}, 20'h0);
        p1o.data_oe = 1'b0;
        p1o.strobe_n = 1'b0;
        step(1);
        p1o.strobe_n = 1'b1;
        seen_ack = 1'b0;
        seen_busy = 1'b0;
        for (int i = 0; i < 12; i++) begin
          step(1);
          seen_ack = seen_ack | (p1i.ack_n === 1'b0);
          seen_busy = seen_busy | (p1i.not_ready === 1'b1);
        end
        chk({seen_ack, seen_busy}, 2'b11);
        chk({poe[7:0], p1i.data_in}, {8'h00, FAR_D});
      end else begin
        chk(s1po, {p2o.data_out[7], p2o.data_out[5], p2o.data_out[6], p2o.data_out[4],
          p2o.data_out[0], p2o.data_out[3], p2o.data_out[1], p2o.data_out[2]});
        chk({s2po[7], s2po[5], s2po[4], spo[2], spo[0], s2oe[6]}, {p2o.strobe_n, p2o.linefeed_n,
          p2o.select_in_n, p2o.host_valid, p2o.direction, ~p2o.init_n});
        // data comes back through the serial-one pins, controls from the far pull values
        chk(p2i, {8'h3C, 6'b110101});
      end
    end
    final_report;
  end
endmodule
